// *** src/psl_pkg.sv ***
// Constants for the strap option latch: reset values and control field positions.
// Assumes a single 25 MHz system clock and a synchronous active-low reset.
package psl_pkg;

	// ==========================================================================
	// Control word field positions
	localparam int unsigned CTRL_DUPLEX_BIT   = 8;
	localparam int unsigned CTRL_ISOLATE_BIT  = 10;
	localparam int unsigned CTRL_AUTONEG_BIT  = 12;
	localparam int unsigned CTRL_SPEED_BIT    = 13;

	// ==========================================================================
	// Advertisement word: 100 full, 100 half, 10 full, 10 half ability bits
	localparam logic [15:0] ADV_100_MASK      = 16'h0180;
	localparam logic [15:0] ADV_10_MASK       = 16'h0060;
	localparam logic [15:0] ADV_SELECTOR      = 16'h0001;

	// ==========================================================================
	// Values after reset, equal to the internal pull defaults
	localparam logic        RST_ISOLATE       = 1'b0;
	localparam logic        RST_SPEED         = 1'b1;
	localparam logic        RST_DUPLEX        = 1'b1;
	localparam logic        RST_AUTONEG       = 1'b1;
	localparam logic        RST_ADDR_UNIQUE   = 1'b0;
	localparam logic        RST_NAND_N        = 1'b1;

endpackage : psl_pkg

// *** src/psl_capture_bit.sv ***
// One strap capture flop that loads only on the cycle after reset release.
// Assumes the parent raises the load strobe only during reset and on the first cycle after release.
`timescale 1ns/1ns
module psl_capture_bit #(
	parameter logic RESET_VALUE = 1'b0
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Capture control
	input  wire logic load,
	input  wire logic pin,
	// Result
	output logic      value_q
);

	// ==========================================================================
	// Capture register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			value_q <= RESET_VALUE;
		end else if (load) begin
			value_q <= pin;
		end
	end

endmodule : psl_capture_bit

// *** src/psl_strap_latch.sv ***
// Strap option latch: samples six strap pins at reset release and drives PHY configuration.
// Assumes strap pins are synchronous to clk_sys and that board or internal pulls set
// undriven pins to their default levels during reset.
`timescale 1ns/1ns

module psl_strap_latch
	import psl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Strap pins, already resolved with their pulls
	input  wire logic        isolate_strap,
	input  wire logic        speed_strap,
	input  wire logic        duplex_strap,
	input  wire logic        autoneg_enable_strap,
	input  wire logic        addr_zero_unique_strap,
	input  wire logic        nand_tree_strap_n,
	// Software writes to the control word
	input  wire logic        ctrl_wr,
	input  wire logic [15:0] ctrl_wdata,
	// Management address decode
	input  wire logic [4:0]  mgmt_addr,
	input  wire logic [4:0]  own_addr,
	// Configuration outputs
	output logic [15:0]      ctrl_word_q,
	output logic [15:0]      adv_word_q,
	output logic             addr_zero_unique_q,
	output logic             nand_tree_mode_q,
	output logic             addr_match_q,
	output logic             oper_speed_100_q,
	output logic             oper_full_duplex_q
);

	// ==========================================================================
	// Release sequencing: capture on the first edge out of reset, copy the image on the next
	typedef enum logic [1:0] {
		PH_CAPTURE = 2'b00,
		PH_IMAGE   = 2'b01,
		PH_RUN     = 2'b11
	} psl_phase_type;

	psl_phase_type phase_q;
	psl_phase_type phase_d;
	logic          load_now;
	logic          image_now;

	always_comb begin
		phase_d = phase_q;
		case (phase_q)
			PH_CAPTURE: begin
				phase_d = PH_IMAGE;
			end
			PH_IMAGE: begin
				phase_d = PH_RUN;
			end
			PH_RUN: begin
				phase_d = PH_RUN;
			end
			default: begin
				// A stray code settles in run, so the straps are never sampled at an odd time.
				phase_d = PH_RUN;
			end
		endcase
	end

	assign load_now  = (phase_q == PH_CAPTURE);
	assign image_now = (phase_q == PH_IMAGE);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			phase_q <= PH_CAPTURE;
		end else begin
			phase_q <= phase_d;
		end
	end

	// ==========================================================================
	// Capture flops; nothing reloads them until the next release
	logic iso_cap;
	logic spd_cap;
	logic dup_cap;
	logic an_cap;
	logic uniq_cap;
	logic nand_n_cap;

	psl_capture_bit #(.RESET_VALUE(RST_ISOLATE)) u_iso (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (isolate_strap),
		.value_q(iso_cap)
	);

	psl_capture_bit #(.RESET_VALUE(RST_SPEED)) u_spd (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (speed_strap),
		.value_q(spd_cap)
	);

	psl_capture_bit #(.RESET_VALUE(RST_DUPLEX)) u_dup (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (duplex_strap),
		.value_q(dup_cap)
	);

	psl_capture_bit #(.RESET_VALUE(RST_AUTONEG)) u_an (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (autoneg_enable_strap),
		.value_q(an_cap)
	);

	psl_capture_bit #(.RESET_VALUE(RST_ADDR_UNIQUE)) u_uniq (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (addr_zero_unique_strap),
		.value_q(uniq_cap)
	);

	psl_capture_bit #(.RESET_VALUE(RST_NAND_N)) u_nand (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.load   (load_now),
		.pin    (nand_tree_strap_n),
		.value_q(nand_n_cap)
	);

	// ==========================================================================
	// Control word: strap image at release, then software owns it
	wire  [15:0] img_speed   = 16'(spd_cap) << CTRL_SPEED_BIT;
	wire  [15:0] img_autoneg = 16'(an_cap)  << CTRL_AUTONEG_BIT;
	wire  [15:0] img_isolate = 16'(iso_cap) << CTRL_ISOLATE_BIT;
	wire  [15:0] img_duplex  = 16'(dup_cap) << CTRL_DUPLEX_BIT;
	wire  [15:0] strap_ctrl  = img_speed | img_autoneg | img_isolate | img_duplex;

	// Captures land one cycle after the strobe, so the image is copied a cycle later.
	logic [15:0] ctrl_word_d;
	wire  [15:0] ctrl_rst = (16'(RST_SPEED)   << CTRL_SPEED_BIT)
	                      | (16'(RST_AUTONEG) << CTRL_AUTONEG_BIT)
	                      | (16'(RST_ISOLATE) << CTRL_ISOLATE_BIT)
	                      | (16'(RST_DUPLEX)  << CTRL_DUPLEX_BIT);

	// A write on the image cycle is lost: the strap image has priority.
	assign ctrl_word_d = image_now ? strap_ctrl :
	                     ctrl_wr   ? ctrl_wdata :
	                                 ctrl_word_q;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_word_q <= ctrl_rst;
		end else begin
			ctrl_word_q <= ctrl_word_d;
		end
	end

	// ==========================================================================
	// Advertisement, operating mode and address decode
	wire [15:0] adv_rst   = ADV_SELECTOR | ADV_10_MASK | (RST_SPEED ? ADV_100_MASK : 16'h0000);
	wire [15:0] adv_100   = spd_cap ? ADV_100_MASK : 16'h0000;
	wire [15:0] adv_d     = ADV_SELECTOR | ADV_10_MASK | adv_100;
	wire        an_on     = ctrl_word_q[CTRL_AUTONEG_BIT];
	// With autonegotiation on, the best advertised mode is shown until a partner result exists.
	wire        spd_d     = an_on ? spd_cap : ctrl_word_q[CTRL_SPEED_BIT];
	wire        fdx_d     = an_on ? 1'b1 : ~ctrl_word_q[CTRL_DUPLEX_BIT];
	wire        zero_hit  = (mgmt_addr == 5'h00) & ~uniq_cap;
	wire        match_d   = (mgmt_addr == own_addr) | zero_hit;

	// Strap images follow only the capture flops, never the pins.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			adv_word_q         <= adv_rst;
			addr_zero_unique_q <= RST_ADDR_UNIQUE;
			nand_tree_mode_q   <= ~RST_NAND_N;
		end else begin
			adv_word_q         <= adv_d;
			addr_zero_unique_q <= uniq_cap;
			nand_tree_mode_q   <= ~nand_n_cap;
		end
	end

	// Address decode, one cycle behind the management address.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			addr_match_q <= 1'b0;
		end else begin
			addr_match_q <= match_d;
		end
	end

	// Operating mode follows the control word one cycle later.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			oper_speed_100_q   <= RST_SPEED;
			oper_full_duplex_q <= ~RST_DUPLEX;
		end else begin
			oper_speed_100_q   <= spd_d;
			oper_full_duplex_q <= fdx_d;
		end
	end

endmodule : psl_strap_latch

// *** test/psl_strap_board.sv ***
// Board model: strap pull resistors and an optional bench drive on each pin.
// Assumes the bench drives pins only to force a strap or mimic pins turned output.
`timescale 1ns/1ns
module psl_strap_board (
	// Bench drive
	input  wire logic [5:0] drv_en,
	input  wire logic [5:0] drv_val,
	// Pin levels
	output logic            isolate_strap,
	output logic            speed_strap,
	output logic            duplex_strap,
	output logic            autoneg_enable_strap,
	output logic            addr_zero_unique_strap,
	output logic            nand_tree_strap_n
);
	// A floating pin settles to its pull, so isolate and address zero read low.
	assign {isolate_strap, speed_strap, duplex_strap, autoneg_enable_strap,
		addr_zero_unique_strap, nand_tree_strap_n} = drv_en & drv_val | ~drv_en & 6'h1D;
endmodule : psl_strap_board

// *** test/psl_strap_latch_properties.sv ***
// Checker for the strap latch: capture at release, hold, and forced mode.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module psl_chk (
	// Clock, reset and straps
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        isolate_strap,
	input wire logic        speed_strap,
	input wire logic        duplex_strap,
	input wire logic        autoneg_enable_strap,
	input wire logic        addr_zero_unique_strap,
	input wire logic        nand_tree_strap_n,
	// Outputs
	input wire logic [15:0] ctrl_word_q,
	input wire logic [15:0] adv_word_q,
	input wire logic        addr_zero_unique_q,
	input wire logic        nand_tree_mode_q,
	input wire logic        oper_speed_100_q,
	input wire logic        oper_full_duplex_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_rel;
		reset_n && !$past(reset_n);
	endsequence
	a_iso_load: assert property (s_rel |-> ##2 ctrl_word_q[10] == $past(isolate_strap, 2))
		else $error("isolate bit wrong");
	a_speed_load: assert property (s_rel |-> ##2 ctrl_word_q[13] == $past(speed_strap, 2))
		else $error("speed bit wrong");
	a_duplex_load: assert property (s_rel |-> ##2 ctrl_word_q[8] == $past(duplex_strap, 2))
		else $error("duplex bit wrong");
	a_aneg_load: assert property (s_rel |-> ##2 ctrl_word_q[12] == $past(autoneg_enable_strap, 2))
		else $error("autoneg bit wrong");
	a_adv_speed: assert property (s_rel |-> ##2 adv_word_q[8:7] == {2{$past(speed_strap, 2)}})
		else $error("advertised speed wrong");
	a_addr_mode: assert property (s_rel |-> ##2 addr_zero_unique_q == $past(addr_zero_unique_strap, 2))
		else $error("address zero mode wrong");
	a_nand_load: assert property (s_rel |-> ##2 nand_tree_mode_q != $past(nand_tree_strap_n, 2))
		else $error("test mode wrong");
	a_capture_hold: assert property ($past(reset_n, 3) & $past(reset_n, 2) & $past(reset_n) |-> $stable(adv_word_q) && $stable(nand_tree_mode_q) && $stable(addr_zero_unique_q))
		else $error("captured value moved");
	a_forced_mode: assert property (!ctrl_word_q[12] |=> oper_speed_100_q == $past(ctrl_word_q[13]) && oper_full_duplex_q != $past(ctrl_word_q[8]))
		else $error("forced mode wrong");
endmodule : psl_chk
bind psl_strap_latch psl_chk chk_u (
	.clk_sys               (clk_sys),
	.reset_n               (reset_n),
	.isolate_strap         (isolate_strap),
	.speed_strap           (speed_strap),
	.duplex_strap          (duplex_strap),
	.autoneg_enable_strap  (autoneg_enable_strap),
	.addr_zero_unique_strap(addr_zero_unique_strap),
	.nand_tree_strap_n     (nand_tree_strap_n),
	.ctrl_word_q           (ctrl_word_q),
	.adv_word_q            (adv_word_q),
	.addr_zero_unique_q    (addr_zero_unique_q),
	.nand_tree_mode_q      (nand_tree_mode_q),
	.oper_speed_100_q      (oper_speed_100_q),
	.oper_full_duplex_q    (oper_full_duplex_q)
);

// *** test/test_psl_strap_latch.sv ***
// Testbench: random straps over repeated resets, writes and address decode.
// Assumes the board model supplies strap levels and the checker is bound.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", n, e, a); end end
module test_psl_strap_latch;
	logic        clk_sys = 0, reset_n = 0, ctrl_wr = 0;
	logic [15:0] ctrl_wdata = 16'h0000, w, c0;
	logic [4:0]  mgmt_addr = 5'h00, own_addr = 5'h01;
	logic [5:0]  drv_en = 6'h00, drv_val = 6'h00, cap;
	wire  [15:0] ctrl_word_q, adv_word_q;
	wire         isolate_strap, speed_strap, duplex_strap, autoneg_enable_strap;
	wire         addr_zero_unique_strap, nand_tree_strap_n, addr_zero_unique_q;
	wire         nand_tree_mode_q, addr_match_q, oper_speed_100_q, oper_full_duplex_q;
	int          mismatches = 0, tests_run = 0, cyc = 0;
	psl_strap_board brd_u (.*);
	psl_strap_latch dut_u (.*);
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (++cyc > 3000) begin
		mismatches++;
		conclude();
	end
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	function automatic logic [15:0] exp_ctrl(logic [5:0] c);
		return {2'b00, c[4], c[2], 1'b0, c[5], 1'b0, c[3], 8'h00};
	endfunction : exp_ctrl
	task automatic boot(logic [5:0] e, logic [5:0] v);
		reset_n = 0;
		drv_en = e;
		drv_val = v;
		repeat (3) @(negedge clk_sys);
		cap = {isolate_strap, speed_strap, duplex_strap, autoneg_enable_strap,
			addr_zero_unique_strap, nand_tree_strap_n};
		reset_n = 1;
		repeat (3) @(negedge clk_sys);
		drv_en = 6'($urandom);
		drv_val = 6'($urandom);
		own_addr = 5'($urandom_range(31, 1));
		mgmt_addr = 5'h00;
		@(negedge clk_sys);
		c0 = ctrl_word_q;
		`CHK("ctrl", exp_ctrl(cap), ctrl_word_q)
		`CHK("adv", cap[4] ? 16'h01E1 : 16'h0061, adv_word_q)
		`CHK("unique", cap[1], addr_zero_unique_q)
		`CHK("nand", ~cap[0], nand_tree_mode_q)
		`CHK("match0", ~cap[1], addr_match_q)
		`CHK("oper", cap[2] ? {cap[4], 1'b1} : {cap[4], ~cap[3]}, {oper_speed_100_q, oper_full_duplex_q})
		w = 16'($urandom);
		ctrl_wr = 1;
		ctrl_wdata = w;
		@(negedge clk_sys);
		ctrl_wr = 0;
		mgmt_addr = own_addr;
		@(negedge clk_sys);
		`CHK("write", w, ctrl_word_q)
		`CHK("wmode", w[12] ? {cap[4], 1'b1} : {w[13], ~w[8]}, {oper_speed_100_q, oper_full_duplex_q})
		`CHK("own", 1'b1, addr_match_q)
		$display("Test done, straps %b", cap);
	endtask : boot
	initial begin
		void'($urandom(10426));
		boot(6'h00, 6'h00);
		`CHK("default", 16'h3100, c0)
		boot(6'h3F, 6'h00);
		boot(6'h3F, 6'h3F);
		for (int i = 0; i < 10; i++) boot(6'($urandom), 6'($urandom));
		conclude();
	end
endmodule : test_psl_strap_latch
